// file: src/asc_seq_ctrl.sv
// Purpose: sequences sample and convert phases and hands results onward
// Assumes: analog codes and trigger arrive asynchronously on pins
// Notes: all sequencing advances on the divided converter clock tick
//
// Chosen here: the strobed register port and the placing of the registers.

`timescale 1ns/1ps

module asc_seq_ctrl import asc_pkg::*; (
	input wire logic core_clk_i, // core clock, 50 MHz
	input wire logic srst_i, // sync reset, high
	input wire logic [ADDR_W-1:0] addr_i, // register index
	input wire logic [DATA_W-1:0] wr_data_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [DATA_W-1:0] rd_data_o, // read data, next cycle
	input wire logic trig_i, // external start trigger pin
	input wire logic [CODE_W-1:0] code_a_i, // channel a code pins
	input wire logic [CODE_W-1:0] code_b_i, // channel b code pins
	output logic result_valid_o, // result word valid
	output logic [WORD_W-1:0] result_data_o, // result word
	input wire logic result_ready_i, // bus controller takes word
	output logic busy_o // sequencer or converter active
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic trig_s1, trig_s2, trig_s3;
	logic [CODE_W-1:0] code_a_s1, code_a_s2;
	logic [CODE_W-1:0] code_b_s1, code_b_s2;
	logic trig_rise;

	// three stages on the trigger, two on each code; the codes are assumed steady around the sample end
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
			code_a_s1 <= '0;
			code_a_s2 <= '0;
			code_b_s1 <= '0;
			code_b_s2 <= '0;
		end else begin
			trig_s1 <= trig_i;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
			code_a_s1 <= code_a_i;
			code_a_s2 <= code_a_s1;
			code_b_s1 <= code_b_i;
			code_b_s2 <= code_b_s1;
		end
	end

	// edge detect looks only at the second stage and later
	assign trig_rise = trig_s2 & ~trig_s3;

	// ************************************************************
	// declarations
	// ************************************************************
	logic tick;
	logic simul, next_simul;
	logic ovl_block, next_ovl_block;
	logic [CT_DIV_W-1:0] div_sel, next_div_sel;
	logic [ACQ_W-1:0] acq_len, next_acq_len;
	logic [SLOT_W-1:0] series_last, next_series_last;
	logic trig_pend, next_trig_pend;
	logic [DATA_W-1:0] next_rd_data;
	logic [CODE_W-1:0] first_res, next_first_res;
	logic [CODE_W-1:0] last_a, next_last_a;
	logic [CODE_W-1:0] last_b, next_last_b;
	logic sw_trig;

	asc_state_t state, next_state;
	logic [ACQ_W-1:0] samp_cnt, next_samp_cnt;
	logic [SLOT_W-1:0] slot, next_slot;
	logic first_of_series, next_first_of_series;
	logic conv_busy, next_conv_busy;
	logic [CNT_W-1:0] conv_cnt, next_conv_cnt;
	logic [WORD_W-1:0] conv_word, next_conv_word;
	logic hand_pend, next_hand_pend;
	logic hand_lat, next_hand_lat;
	logic [WORD_W-1:0] hand_word, next_hand_word;
	logic next_busy;

	logic series_start;
	logic samp_min;
	logic end_ok;
	logic sample_end;
	logic buf_in_valid;
	logic buf_in_ready;

	// field picks from a result word
	function automatic logic [CODE_W-1:0] word_a(input logic [WORD_W-1:0] w);
		word_a = w[CODE_W-1:0];
	endfunction : word_a

	function automatic logic [CODE_W-1:0] word_b(input logic [WORD_W-1:0] w);
		word_b = w[2*CODE_W-1:CODE_W];
	endfunction : word_b

	function automatic logic [SLOT_W-1:0] word_slot(
		input logic [WORD_W-1:0] w);
		word_slot = w[2*CODE_W+SLOT_W-1:2*CODE_W];
	endfunction : word_slot

	// ************************************************************
	// converter clock enable
	// ************************************************************
	asc_clk_div u_div (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.div_sel_i(div_sel),
		.tick_o(tick)
	);

	// ************************************************************
	// register port
	// ************************************************************
	// writes and reads; a trigger arriving as the series starts is kept
	always_comb begin
		next_simul = simul;
		next_ovl_block = ovl_block;
		next_div_sel = div_sel;
		next_acq_len = acq_len;
		next_series_last = series_last;
		sw_trig = 1'b0;
		next_rd_data = '0;
		if (wr_i) begin
			if (addr_i == REG_CTRL_TWO) begin
				next_simul = wr_data_i[CT_SIMUL_BIT];
				next_ovl_block = wr_data_i[CT_OVL_BLOCK_BIT];
				next_div_sel = wr_data_i[CT_DIV_LSB +: CT_DIV_W];
			end else if (addr_i == REG_ACQ_LEN) begin
				next_acq_len = wr_data_i[ACQ_W-1:0];
			end else if (addr_i == REG_SERIES) begin
				next_series_last = wr_data_i[SLOT_W-1:0];
			end else if (addr_i == REG_CMD) begin
				sw_trig = wr_data_i[CMD_SW_TRIG_BIT];
			end
		end
		if (rd_i) begin
			if (addr_i == REG_CTRL_TWO) begin
				next_rd_data[CT_SIMUL_BIT] = simul;
				next_rd_data[CT_OVL_BLOCK_BIT] = ovl_block;
				next_rd_data[CT_DIV_LSB +: CT_DIV_W] = div_sel;
			end else if (addr_i == REG_ACQ_LEN) begin
				next_rd_data[ACQ_W-1:0] = acq_len;
			end else if (addr_i == REG_SERIES) begin
				next_rd_data[SLOT_W-1:0] = series_last;
			end else if (addr_i == REG_STATUS) begin
				// pending trigger at bit 0 keeps the active bit visible
				next_rd_data = {7'h00, slot, hand_lat, hand_pend,
					conv_busy, (state != ST_IDLE), trig_pend};
			end else if (addr_i == REG_FIRST_RES) begin
				next_rd_data[CODE_W-1:0] = first_res;
			end else if (addr_i == REG_LAST_A) begin
				next_rd_data[CODE_W-1:0] = last_a;
			end else if (addr_i == REG_LAST_B) begin
				next_rd_data[CODE_W-1:0] = last_b;
			end
		end
		// set wins over the clear by a series start
		next_trig_pend = (trig_pend & ~series_start) | trig_rise | sw_trig;
	end

	// registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			simul <= CT_SIMUL_RST;
			ovl_block <= CT_OVL_BLOCK_RST;
			div_sel <= CT_DIV_RST;
			acq_len <= ACQ_LEN_RST;
			series_last <= SERIES_LAST_RST;
			trig_pend <= 1'b0;
			rd_data_o <= '0;
		end else begin
			simul <= next_simul;
			ovl_block <= next_ovl_block;
			div_sel <= next_div_sel;
			acq_len <= next_acq_len;
			series_last <= next_series_last;
			trig_pend <= next_trig_pend;
			rd_data_o <= next_rd_data;
		end
	end

	// ************************************************************
	// sequencer, converter core and hand-off stage
	// ************************************************************
	// window reached after acq_len + 1 ticks of sampling
	assign samp_min = (samp_cnt == acq_len);
	// sampling may end when the core is free or ends this tick (13th),
	// but never while a result waits to be presented (14th)
	assign end_ok = ~hand_pend & (~conv_busy | conv_cnt == CONV_LAST);
	assign sample_end = tick & (state == ST_SAMPLE) & samp_min & end_ok;
	assign series_start = tick & (state == ST_IDLE) & trig_pend &
		(~ovl_block | ~conv_busy);
	assign buf_in_valid = tick & hand_pend & buf_in_ready;

	always_comb begin
		next_state = state;
		next_samp_cnt = samp_cnt;
		next_slot = slot;
		next_first_of_series = first_of_series;
		next_conv_busy = conv_busy;
		next_conv_cnt = conv_cnt;
		next_conv_word = conv_word;
		next_hand_pend = hand_pend;
		next_hand_lat = hand_lat;
		next_hand_word = hand_word;
		next_first_res = first_res;
		next_last_a = last_a;
		next_last_b = last_b;

		// 15th cycle: result register latch
		if (tick && hand_lat) begin
			next_hand_lat = 1'b0;
			next_last_a = word_a(hand_word);
			next_last_b = word_b(hand_word);
			if (word_slot(hand_word) == '0) begin
				next_first_res = word_a(hand_word);
			end
		end
		// 14th cycle: present to the bus controller; a full buffer stalls
		if (buf_in_valid) begin
			next_hand_pend = 1'b0;
			next_hand_lat = 1'b1;
		end
		// converter core counts 13 cycles, then moves to hand-off
		if (tick && conv_busy) begin
			if (conv_cnt == CONV_LAST) begin
				if (!hand_pend) begin
					next_conv_busy = 1'b0;
					next_hand_pend = 1'b1;
					next_hand_word = conv_word;
				end
			end else begin
				next_conv_cnt = conv_cnt + 4'h1;
			end
		end

		case (state)
			ST_IDLE: begin
				if (series_start) begin
					next_state = ST_SAMPLE;
					next_slot = '0;
					next_samp_cnt = '0;
					next_first_of_series = 1'b1;
				end
			end
			ST_WAIT: begin
				// hold off sampling until the core is idle
				if (tick && !conv_busy) begin
					next_state = ST_SAMPLE;
					next_samp_cnt = '0;
				end
			end
			ST_SAMPLE: begin
				if (sample_end) begin
					// a back-to-back window shorter than the core simply
					// waits here, so it ends on the 13th cycle
					next_conv_busy = 1'b1;
					next_conv_cnt = '0;
					next_conv_word = {first_of_series & ~ovl_block,
						simul, slot, simul ? code_b_s2 : {CODE_W{1'b0}},
						code_a_s2};
					next_first_of_series = 1'b0;
					next_samp_cnt = '0;
					if (slot == series_last) begin
						next_state = ST_IDLE;
					end else begin
						next_slot = slot + 4'h1;
						next_state = ovl_block ? ST_WAIT : ST_SAMPLE;
					end
				end else if (tick && !samp_min) begin
					next_samp_cnt = samp_cnt + 6'h01;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_busy = (next_state != ST_IDLE) | next_conv_busy |
			next_hand_pend | next_hand_lat;
	end

	// registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
			samp_cnt <= '0;
			slot <= '0;
			first_of_series <= 1'b0;
			conv_busy <= 1'b0;
			conv_cnt <= '0;
			conv_word <= '0;
			hand_pend <= 1'b0;
			hand_lat <= 1'b0;
			hand_word <= '0;
			first_res <= '0;
			last_a <= '0;
			last_b <= '0;
			busy_o <= 1'b0;
		end else begin
			state <= next_state;
			samp_cnt <= next_samp_cnt;
			slot <= next_slot;
			first_of_series <= next_first_of_series;
			conv_busy <= next_conv_busy;
			conv_cnt <= next_conv_cnt;
			conv_word <= next_conv_word;
			hand_pend <= next_hand_pend;
			hand_lat <= next_hand_lat;
			hand_word <= next_hand_word;
			first_res <= next_first_res;
			last_a <= next_last_a;
			last_b <= next_last_b;
			busy_o <= next_busy;
		end
	end

	// ************************************************************
	// result buffer toward the bus controller
	// ************************************************************
	// two entries absorb a short stall; a longer one holds the core
	asc_buf u_buf (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.in_valid_i(buf_in_valid),
		.in_data_i(hand_word),
		.in_ready_o(buf_in_ready),
		.out_valid_o(result_valid_o),
		.out_data_o(result_data_o),
		.out_ready_i(result_ready_i)
	);

endmodule : asc_seq_ctrl

// file: src/asc_pkg.sv
// Purpose: shared constants and types for the converter sequencing control
// Assumes: one core clock; converter clock is a divided enable pulse
// Notes: register indices are word indices on the plain register port

package asc_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int CODE_W = 12;
	localparam int SLOT_W = 4;
	localparam int ACQ_W = 6;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CNT_W = 4;
	// result word: suspect, simultaneous, slot, channel b, channel a
	localparam int WORD_W = 2 + SLOT_W + 2 * CODE_W;
	localparam int BUF_DEPTH = 2;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [ADDR_W-1:0] REG_CTRL_TWO = 4'h0;
	localparam logic [ADDR_W-1:0] REG_ACQ_LEN = 4'h1;
	localparam logic [ADDR_W-1:0] REG_SERIES = 4'h2;
	localparam logic [ADDR_W-1:0] REG_CMD = 4'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_FIRST_RES = 4'h5;
	localparam logic [ADDR_W-1:0] REG_LAST_A = 4'h6;
	localparam logic [ADDR_W-1:0] REG_LAST_B = 4'h7;

	// converter_control_two fields
	localparam int CT_SIMUL_BIT = 0;
	localparam int CT_OVL_BLOCK_BIT = 1;
	localparam int CT_DIV_LSB = 4;
	localparam int CT_DIV_W = 2;
	// command field
	localparam int CMD_SW_TRIG_BIT = 0;

	// reset values
	localparam logic CT_SIMUL_RST = 1'h0;
	localparam logic CT_OVL_BLOCK_RST = 1'h0;
	localparam logic [CT_DIV_W-1:0] CT_DIV_RST = 2'h0;
	localparam logic [ACQ_W-1:0] ACQ_LEN_RST = 6'h06;
	localparam logic [SLOT_W-1:0] SERIES_LAST_RST = 4'h0;

	// ************************************************************
	// converter timing, in converter clock cycles after sampling
	// ************************************************************
	localparam logic [CNT_W-1:0] CONV_CYCLES = 4'hD;
	localparam logic [CNT_W-1:0] PRESENT_CYCLE = 4'hE;
	localparam logic [CNT_W-1:0] LATCH_CYCLE = 4'hF;
	// count value at the tick that completes the last converting cycle
	localparam logic [CNT_W-1:0] CONV_LAST = CONV_CYCLES - 4'h1;

	// divider select codes
	localparam logic [CT_DIV_W-1:0] DIV_BY1 = 2'h0;
	localparam logic [CT_DIV_W-1:0] DIV_BY2 = 2'h1;
	localparam logic [1:0] DIV_MASK1 = 2'h0;
	localparam logic [1:0] DIV_MASK2 = 2'h1;
	localparam logic [1:0] DIV_MASK4 = 2'h3;

	// ************************************************************
	// sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_SAMPLE = 3'h4
	} asc_state_t;

endpackage : asc_pkg

// file: src/asc_clk_div.sv
// Purpose: converter clock enable from the core clock
// Assumes: select code 0 = every clock, 1 = every 2nd, other = every 4th
// Notes: tick is one core clock long

`timescale 1ns/1ps

module asc_clk_div import asc_pkg::*; (
	input wire logic core_clk_i, // core clock
	input wire logic srst_i, // sync reset, high
	input wire logic [CT_DIV_W-1:0] div_sel_i, // divide select
	output logic tick_o // converter clock enable
);

	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic next_tick;
	logic [1:0] mask;

	// terminal count from the select; change of select takes effect on the next clock
	always_comb begin
		if (div_sel_i == DIV_BY1) begin
			mask = DIV_MASK1;
		end else if (div_sel_i == DIV_BY2) begin
			mask = DIV_MASK2;
		end else begin
			mask = DIV_MASK4;
		end
		next_cnt = ((cnt & mask) == mask) ? 2'h0 : cnt + 2'h1;
		next_tick = ((cnt & mask) == mask);
	end

	// registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cnt <= 2'h0;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end

endmodule : asc_clk_div

// file: src/asc_buf.sv
// Purpose: two-entry result buffer toward the bus controller
// Assumes: push only while in_ready_o is high
// Notes: outputs come from flip-flops; no bypass, so one cycle of latency

`timescale 1ns/1ps

module asc_buf import asc_pkg::*; (
	input wire logic core_clk_i, // core clock
	input wire logic srst_i, // sync reset, high
	input wire logic in_valid_i, // push strobe
	input wire logic [WORD_W-1:0] in_data_i, // pushed word
	output logic in_ready_o, // room for a word
	output logic out_valid_o, // head word valid
	output logic [WORD_W-1:0] out_data_o, // head word
	input wire logic out_ready_i // bus controller takes head
);

	logic [WORD_W-1:0] mem [BUF_DEPTH];
	logic [WORD_W-1:0] next_mem [BUF_DEPTH];
	logic [1:0] count;
	logic [1:0] next_count;
	logic rd_ptr;
	logic next_rd_ptr;
	logic wr_ptr;
	logic next_wr_ptr;
	logic push;
	logic pop;

	// pointer and count update; ready and valid derive from the stored count
	always_comb begin
		push = in_valid_i & in_ready_o;
		pop = out_valid_o & out_ready_i;
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_mem[wr_ptr] = in_data_i;
			next_wr_ptr = ~wr_ptr;
		end
		if (pop) begin
			next_rd_ptr = ~rd_ptr;
		end
		next_count = count + {1'b0, push} - {1'b0, pop};
	end

	// registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			mem[0] <= '0;
			mem[1] <= '0;
			count <= 2'h0;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else begin
			mem <= next_mem;
			count <= next_count;
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			in_ready_o <= (next_count != 2'h2);
			out_valid_o <= (next_count != 2'h0);
			out_data_o <= (push && next_count == 2'h1) ?
				in_data_i : next_mem[next_rd_ptr];
		end
	end

endmodule : asc_buf

// file: verif/asc_chk_asserts.sv
// Purpose: port checks for the converter sequencing control
// Assumes: control writes are made only while the block is idle
// Notes: timing checks hold only with the converter clock undivided

`timescale 1ns/1ps

module asc_chk import asc_pkg::*; (
	input wire logic core_clk_i, // core clock
	input wire logic srst_i, // sync reset, high
	input wire logic [ADDR_W-1:0] addr_i, // register index
	input wire logic [DATA_W-1:0] wr_data_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [DATA_W-1:0] rd_data_o, // read data
	input wire logic trig_i, // trigger pin
	input wire logic [CODE_W-1:0] code_a_i, // channel a code
	input wire logic [CODE_W-1:0] code_b_i, // channel b code
	input wire logic result_valid_o, // word valid
	input wire logic [WORD_W-1:0] result_data_o, // result word
	input wire logic result_ready_i, // word taken
	input wire logic busy_o // block active
);
	// ****
	// helper state
	// ****
	logic [ACQ_W-1:0] acq;
	logic ovl, arm, hold;
	logic [CT_DIV_W-1:0] div;
	logic [9:0] cnt;
	logic [5:0] gap;
	logic [SLOT_W-1:0] slot;
	logic sus;
	assign slot = result_data_o[2*CODE_W+:SLOT_W];
	assign sus = result_data_o[WORD_W-1];

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	// shadow writes; a stall spoils spacing until the block is idle again
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			acq <= ACQ_LEN_RST;
			ovl <= CT_OVL_BLOCK_RST;
			div <= CT_DIV_RST;
			arm <= 1'b0;
			hold <= 1'b0;
			cnt <= 10'h3FF;
			gap <= 6'h3F;
		end else begin
			if (wr_i && addr_i == REG_ACQ_LEN)
				acq <= wr_data_i[ACQ_W-1:0];
			if (wr_i && addr_i == REG_CTRL_TWO) begin
				ovl <= wr_data_i[CT_OVL_BLOCK_BIT];
				div <= wr_data_i[CT_DIV_LSB+:CT_DIV_W];
			end
			cnt <= (cnt == 10'h3FF) ? cnt : cnt + 10'h001;
			gap <= (gap == 6'h3F) ? gap : gap + 6'h01;
			if ($rose(result_valid_o)) begin
				arm <= 1'b0;
				gap <= 6'h01;
			end
			if (wr_i && addr_i == REG_CMD && wr_data_i[CMD_SW_TRIG_BIT]
				&& !busy_o && !result_valid_o) begin
				cnt <= 10'h000;
				arm <= (div == DIV_BY1);
			end
			if (!busy_o && !result_valid_o)
				hold <= 1'b0;
			else if (result_valid_o && !result_ready_i)
				hold <= 1'b1;
		end
	end

	property p_rd_idle;
		!rd_i |=> rd_data_o == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	property p_rd_unmapped;
		rd_i && addr_i > REG_LAST_B |=> rd_data_o == '0;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read not zero");
	property p_hold;
		result_valid_o && !result_ready_i
			|=> result_valid_o && $stable(result_data_o);
	endproperty
	a_hold: assert property (p_hold) else $error("word dropped in stall");
	property p_sus_clear;
		result_valid_o && (ovl || slot != '0) |-> !sus;
	endproperty
	a_sus_clear: assert property (p_sus_clear)
		else $error("word wrongly marked suspect");
	property p_sus_set;
		result_valid_o && !ovl && slot == '0 |-> sus;
	endproperty
	a_sus_set: assert property (p_sus_set)
		else $error("first word not marked suspect");
	property p_seq_b;
		result_valid_o && !result_data_o[WORD_W-2]
			|-> result_data_o[2*CODE_W-1:CODE_W] == '0;
	endproperty
	a_seq_b: assert property (p_seq_b) else $error("channel b set");
	// start tick, acq+1 sampling, 13 converting, push on the 14th
	property p_latency;
		arm && $rose(result_valid_o)
			|-> cnt == 10'(acq) + 10'd16;
	endproperty
	a_latency: assert property (p_latency)
		else $error("result latency wrong");
	property p_spacing;
		$rose(result_valid_o) && !hold && div == DIV_BY1
			|-> gap >= 6'd13 && gap != 6'd14;
	endproperty
	a_spacing: assert property (p_spacing)
		else $error("result spacing wrong");
endmodule : asc_chk

// file: verif/asc_bus_ctl.sv
// Purpose: bus controller model that takes finished result words
// Assumes: the bench raises stall_i only to test buffering
// Notes: logs every taken word with the cycle it was taken in

`timescale 1ns/1ps

module asc_bus_ctl import asc_pkg::*; (
	input wire logic core_clk_i, // core clock
	input wire logic srst_i, // sync reset, high
	input wire logic stall_i, // bench asks for a stall
	input wire logic valid_i, // word offered
	input wire logic [WORD_W-1:0] data_i, // offered word
	output logic ready_o // word taken
);
	// ****
	// result latch
	// ****
	logic [WORD_W-1:0] q[$];
	int t[$];
	int cyc = 0;
	// ready falls only on command, so no word is refused by surprise
	assign ready_o = !stall_i;
	// keep every handshake; the bench discards what it must
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (!srst_i && valid_i && ready_o) begin
			q.push_back(data_i);
			t.push_back(cyc);
		end
	end
endmodule : asc_bus_ctl

// file: verif/tb.sv
// Purpose: register and conversion series tests of the sequencing control
// Assumes: converter codes held steady on the pins during a series
// Notes: gaps and latencies are measured in the bus controller model

`timescale 1ns/1ps

module tb import asc_pkg::*;;
	// ****
	// bench
	// ****
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic trig_i = 1'b0;
	logic stall = 1'b0;
	logic result_valid_o, result_ready_i, busy_o;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wr_data_i = '0;
	logic [DATA_W-1:0] rd_data_o;
	logic [CODE_W-1:0] code_a_i = 12'h5A3;
	logic [CODE_W-1:0] code_b_i = 12'hC3C;
	logic [WORD_W-1:0] result_data_o;
	int n_fail = 0;
	int n_checks = 0;
	int t0, lat, l0;

	always #10 core_clk_i = ~core_clk_i;

	asc_seq_ctrl dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .trig_i(trig_i), .code_a_i(code_a_i),
		.code_b_i(code_b_i), .result_valid_o(result_valid_o),
		.result_data_o(result_data_o), .result_ready_i(result_ready_i),
		.busy_o(busy_o));
	asc_bus_ctl bc (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.stall_i(stall), .valid_i(result_valid_o),
		.data_i(result_data_o), .ready_o(result_ready_i));

	task end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe
	task rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input string nm);
		@(posedge core_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 chk(nm, e, rd_data_o);
	endtask : rdc

	// one series: egap is the exact gap, or the least one when blocking
	task series(input logic [15:0] ctl, input logic [5:0] acq, input int n,
		input int egap, input bit pin);
		logic [WORD_W-1:0] w;
		int k, g;
		wr(REG_CTRL_TWO, ctl);
		wr(REG_ACQ_LEN, {10'h000, acq});
		wr(REG_SERIES, 16'(n - 1));
		bc.q.delete();
		bc.t.delete();
		t0 = bc.cyc;
		if (pin) begin
			@(posedge core_clk_i);
			trig_i <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			trig_i <= 1'b0;
		end else
			wr(REG_CMD, 16'h0001);
		for (k = 0; k < 600 && bc.q.size() < n; k++) begin
			if (k == 300)
				stall <= 1'b0;
			@(posedge core_clk_i);
		end
		for (k = 0; k < 100 && busy_o !== 1'b0; k++)
			@(posedge core_clk_i);
		chk("word count", n, bc.q.size());
		chk("idle", 1'b0, busy_o);
		if (bc.t.size() > 0)
			lat = bc.t[0] - t0;
		for (k = 0; k < bc.q.size(); k++) begin
			w = bc.q[k];
			chk("slot", k, w[2*CODE_W+:SLOT_W]);
			chk("suspect", k == 0 && !ctl[1], w[WORD_W-1]);
			chk("simultaneous", ctl[0], w[WORD_W-2]);
			chk("chan a", code_a_i, w[CODE_W-1:0]);
			chk("chan b", ctl[0] ? code_b_i : 12'h000, w[23:12]);
			g = (k > 0) ? bc.t[k] - bc.t[k-1] : 0;
			if (k > 0 && egap > 0)
				chk("gap", 1, ctl[1] ? g >= egap : g == egap);
		end
		$display("series ctl %0h window %0d done", ctl, acq);
	endtask : series

	// stop a hang well past the longest expected run
	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_fail++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge core_clk_i);
		srst_i <= 1'b0;
		rdc(REG_CTRL_TWO, 16'h0000, "ctrl two reset");
		rdc(REG_ACQ_LEN, 16'h0006, "window reset");
		rdc(REG_SERIES, 16'h0000, "series reset");
		wr(4'hF, 16'hFFFF);
		rdc(4'hF, 16'h0000, "unmapped");
		wr(REG_ACQ_LEN, 16'hFFFF);
		rdc(REG_ACQ_LEN, 16'h003F, "window field");
		$display("register test done");
		series(16'h0000, 6'h00, 1, 0, 1'b0);
		l0 = lat;
		rdc(REG_FIRST_RES, {4'h0, code_a_i}, "first result");
		series(16'h0000, 6'h0A, 1, 0, 1'b0);
		chk("window length", 10, lat - l0);
		series(16'h0000, 6'h06, 4, 13, 1'b0);
		rdc(REG_STATUS, 16'h0060, "status idle");
		series(16'h0000, 6'h07, 4, 13, 1'b0);
		series(16'h0002, 6'h06, 4, 20, 1'b0);
		rdc(REG_CTRL_TWO, 16'h0002, "ctrl two");
		series(16'h0001, 6'h02, 2, 13, 1'b0);
		rdc(REG_LAST_B, {4'h0, code_b_i}, "last b");
		@(posedge core_clk_i);
		stall <= 1'b1;
		series(16'h0000, 6'h00, 4, 0, 1'b0);
		series(16'h0020, 6'h00, 1, 0, 1'b0);
		chk("quarter clock", 1, lat > 2 * l0);
		series(16'h0010, 6'h00, 1, 0, 1'b1);
		chk("slow clock", 1, lat > l0);
		end_of_test();
	end
endmodule : tb

bind asc_seq_ctrl asc_chk u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
	.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
	.rd_data_o(rd_data_o), .trig_i(trig_i), .code_a_i(code_a_i),
	.code_b_i(code_b_i), .result_valid_o(result_valid_o),
	.result_data_o(result_data_o), .result_ready_i(result_ready_i),
	.busy_o(busy_o));
